// >>> include/xcvr_link_if.sv
`timescale 1ns/1ps
interface xcvr_link_if;
    // --------------------------------------------------------------
    // data interface and load strobe between host and device
    // --------------------------------------------------------------
    logic data_clock_pin;
    logic data_io_dev_o;
    logic data_io_dev_oe_n;
    logic data_io_host_o;
    logic data_io_host_oe_n;
    logic lock_indicator_pin;
    logic load_strobe;
    logic [6:0] cfg_addr;
    logic [7:0] cfg_data;
    logic cfg_write;

    modport device (
        output data_clock_pin,
        output data_io_dev_o,
        output data_io_dev_oe_n,
        input data_io_host_o,
        input data_io_host_oe_n,
        output lock_indicator_pin,
        input load_strobe,
        input cfg_addr,
        input cfg_data,
        input cfg_write
    );
    modport host (
        input data_clock_pin,
        input data_io_dev_o,
        input data_io_dev_oe_n,
        output data_io_host_o,
        output data_io_host_oe_n,
        input lock_indicator_pin,
        output load_strobe,
        output cfg_addr,
        output cfg_data,
        output cfg_write
    );
endinterface : xcvr_link_if

// >>> include/xcvr_pkg.sv
package xcvr_pkg;
    // --------------------------------------------------------------
    // device control register offsets
    // --------------------------------------------------------------
    localparam logic [6:0] FRONT_END_MODE_CONTROL_OFS = 7'h00;
    localparam logic [6:0] MODULATION_FILTER_CONTROL_OFS = 7'h01;
    localparam logic [6:0] PUMP_AND_OUTPUT_CONTROL_OFS = 7'h02;
    localparam logic [6:0] CLOCK_SHIFT_SELECT_OFS = 7'h06;
    localparam logic [6:0] REFERENCE_DIVIDER_SELECT_OFS = 7'h07;
    localparam logic [7:0] REG_RESET = 8'h00;
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int SYNC_EN_BIT = 3;
    localparam int OP_STATE_HI_BIT = 2;
    localparam int OP_STATE_LO_BIT = 1;
    localparam int LOCK_EN_BIT = 2;
    localparam int PUMP_HI_BIT = 7;
    localparam int SHIFT_HI_BIT = 0;
    localparam int SHIFT_LO_HI_BIT = 7;
    localparam int SHIFT_LO_LO_BIT = 6;
    localparam int REFDIV_HI_BIT = 5;
    localparam logic [2:0] SHIFT_MAX = 3'h6;
    localparam logic [5:0] REFDIV_MIN = 6'h01;
    // --------------------------------------------------------------
    // host register word addresses
    // --------------------------------------------------------------
    localparam logic [3:0] ADR_CFG = 4'h0;
    localparam logic [3:0] ADR_TX = 4'h1;
    localparam logic [3:0] ADR_RX = 4'h2;
    localparam logic [3:0] ADR_STAT = 4'h3;
    localparam logic [3:0] ADR_MASK = 4'h4;
    localparam int ST_LOCK_RISE = 2;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_POWER_DOWN = 2'h0,
        OP_STANDBY = 2'h1,
        OP_RECEIVE = 2'h2,
        OP_TRANSMIT = 2'h3
    } op_state_type;
endpackage : xcvr_pkg

// >>> rtl/bit_rate_divider.sv
`timescale 1ns/1ps
module bit_rate_divider
    import xcvr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic run, // enable, clock held low when low
    input wire logic [5:0] ref_div, // reference divider value
    input wire logic [2:0] shift, // bit-rate shift setting
    output logic bit_clk, // divided bit-rate clock
    output logic rise // one-cycle pulse at bit_clk rise
);
    // ------------------------------------------------------------------
    // half period = ref_div * 2**(6-shift) clocks
    // ------------------------------------------------------------------
    logic [5:0] pre_q; // see RULE12
    logic [6:0] pow_q;
    logic [5:0] div_eff;
    logic [2:0] sh_eff;
    logic [6:0] half_pow;
    logic pre_wrap;

    assign div_eff = (ref_div < REFDIV_MIN) ? REFDIV_MIN : ref_div; // see RULE12
    assign sh_eff = (shift > SHIFT_MAX) ? SHIFT_MAX : shift; // see RULE13
    assign half_pow = 7'(7'h40 >> sh_eff); // see RULE11
    assign pre_wrap = (pre_q == div_eff - 6'h01);
    assign rise = run && pre_wrap && (pow_q == half_pow - 7'h01) && !bit_clk;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 6'h00;
        end else if (!run || pre_wrap) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pow_q <= 7'h00;
            bit_clk <= 1'b0;
        end else if (!run) begin
            pow_q <= 7'h00;
            bit_clk <= 1'b0;
        end else if (pre_wrap) begin
            if (pow_q == half_pow - 7'h01) begin
                pow_q <= 7'h00;
                bit_clk <= !bit_clk; // see RULE11
            end else begin
                pow_q <= pow_q + 7'h01;
            end
        end
    end
endmodule : bit_rate_divider

// >>> rtl/xcvr_device.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: mode field picks down, standby, receive, transmit
// RULE2: lock pin high on lock when enabled
// RULE3: high-current bit selects 500uA else 125uA
// RULE4: async receive: demod data passes through
// RULE5: async transmit: clock off, data to modulator
// RULE6: sync receive outputs recovered bit clock; code outputs the divider bit_clk, not one recovered from the data
// RULE7: sync transmit outputs bit-rate clock
// RULE8: device samples tx data on clock rise
// RULE9: host changes transmit data on clock fall
// RULE10: device updates rx on rise, host samples fall
// RULE11: bit clock = xtal / (div * 2^(7-shift))
// RULE12: reference divider six bits, 1 to 63
// RULE13: bit-rate shift three bits, 0 to 6
// RULE14: host keeps data pin released until sending
// RULE15: in sync mode the device is clock master
// RULE16: host sets bit clock equal to bit rate
// RULE17: writes take effect on load strobe
// RULE18: data clock low when idle or async
module xcvr_device
    import xcvr_pkg::*;
(
    input wire logic clk, // crystal-derived system clock
    input wire logic rstn, // async reset, active low
    xcvr_link_if.device link, // pins toward the host
    input wire logic pll_locked, // synthesizer loop in lock
    input wire logic demod_data, // demodulator output bit
    output logic mod_data, // bit fed to the modulator
    output logic mod_sample, // high each cycle mod_data is sampled, steady in async transmit
    output logic pump_high, // charge pump at 500uA when high
    output logic [1:0] op_state, // active operating state
    output logic [7:0] shadow_rd // shadow contents at cfg_addr
);
    // ------------------------------------------------------------------
    // shadow and active register sets
    // ------------------------------------------------------------------
    logic [7:0] sh_mode_q, sh_filt_q, sh_pump_q, sh_shift_q, sh_ref_q;
    logic [7:0] act_mode_q, act_filt_q, act_pump_q, act_shift_q, act_ref_q;
    logic [2:0] load_sync_q;
    logic [1:0] din_sync_q, lock_sync_q, demod_sync_q;
    logic load_fall;
    logic sync_en, receiving, transmitting, run_clk, bit_clk, bit_rise;
    logic rx_q, lock_q;
    logic [2:0] shift;
    logic [5:0] ref_div;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_mode_q <= REG_RESET;
            sh_filt_q <= REG_RESET;
            sh_pump_q <= REG_RESET;
            sh_shift_q <= REG_RESET;
            sh_ref_q <= REG_RESET;
        end else if (link.cfg_write) begin
            case (link.cfg_addr)
                FRONT_END_MODE_CONTROL_OFS: sh_mode_q <= link.cfg_data;
                MODULATION_FILTER_CONTROL_OFS: sh_filt_q <= link.cfg_data;
                PUMP_AND_OUTPUT_CONTROL_OFS: sh_pump_q <= link.cfg_data;
                CLOCK_SHIFT_SELECT_OFS: sh_shift_q <= link.cfg_data;
                REFERENCE_DIVIDER_SELECT_OFS: sh_ref_q <= link.cfg_data;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        case (link.cfg_addr)
            FRONT_END_MODE_CONTROL_OFS: shadow_rd = sh_mode_q;
            MODULATION_FILTER_CONTROL_OFS: shadow_rd = sh_filt_q;
            PUMP_AND_OUTPUT_CONTROL_OFS: shadow_rd = sh_pump_q;
            CLOCK_SHIFT_SELECT_OFS: shadow_rd = sh_shift_q;
            REFERENCE_DIVIDER_SELECT_OFS: shadow_rd = sh_ref_q;
            default: shadow_rd = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // load strobe fall copies shadow to active
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            load_sync_q <= 3'h0;
        end else begin
            load_sync_q <= {load_sync_q[1:0], link.load_strobe};
        end
    end
    assign load_fall = load_sync_q[2] && !load_sync_q[1];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act_mode_q <= REG_RESET;
            act_filt_q <= REG_RESET;
            act_pump_q <= REG_RESET;
            act_shift_q <= REG_RESET;
            act_ref_q <= REG_RESET;
        end else if (load_fall) begin // see RULE17
            act_mode_q <= sh_mode_q;
            act_filt_q <= sh_filt_q;
            act_pump_q <= sh_pump_q;
            act_shift_q <= sh_shift_q;
            act_ref_q <= sh_ref_q;
        end
    end

    // ------------------------------------------------------------------
    // decoded controls
    // ------------------------------------------------------------------
    assign op_state = {act_mode_q[OP_STATE_HI_BIT],
                       act_mode_q[OP_STATE_LO_BIT]}; // see RULE1
    assign sync_en = act_mode_q[SYNC_EN_BIT];
    assign receiving = (op_state == OP_RECEIVE);
    assign transmitting = (op_state == OP_TRANSMIT);
    assign run_clk = sync_en && (receiving || transmitting); // see RULE18
    assign pump_high = act_pump_q[PUMP_HI_BIT]; // see RULE3
    assign shift = {act_shift_q[SHIFT_HI_BIT], act_ref_q[SHIFT_LO_HI_BIT],
                    act_ref_q[SHIFT_LO_LO_BIT]};
    assign ref_div = act_ref_q[REFDIV_HI_BIT:0];

    bit_rate_divider u_div (
        .clk(clk),
        .rstn(rstn),
        .run(run_clk),
        .ref_div(ref_div),
        .shift(shift),
        .bit_clk(bit_clk),
        .rise(bit_rise)
    );

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            din_sync_q <= 2'h0;
            lock_sync_q <= 2'h0;
            demod_sync_q <= 2'h0;
        end else begin
            din_sync_q <= {din_sync_q[0], link.data_io_host_o};
            lock_sync_q <= {lock_sync_q[0], pll_locked};
            demod_sync_q <= {demod_sync_q[0], demod_data};
        end
    end

    // ------------------------------------------------------------------
    // data path
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_q <= 1'b0;
        end else if (receiving && !sync_en) begin
            rx_q <= demod_sync_q[1]; // see RULE4
        end else if (receiving && bit_rise) begin
            rx_q <= demod_sync_q[1]; // see RULE6 see RULE10
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mod_data <= 1'b0;
            mod_sample <= 1'b0;
        end else begin
            mod_sample <= 1'b0;
            if (transmitting && !sync_en) begin
                mod_data <= din_sync_q[1]; // see RULE5
                mod_sample <= 1'b1;
            end else if (transmitting && bit_rise) begin
                mod_data <= din_sync_q[1]; // see RULE8 see RULE7
                mod_sample <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= act_filt_q[LOCK_EN_BIT] && lock_sync_q[1]; // see RULE2
        end
    end

    assign link.data_clock_pin = bit_clk; // see RULE15
    assign link.data_io_dev_o = rx_q;
    assign link.data_io_dev_oe_n = !receiving;
    assign link.lock_indicator_pin = lock_q;
endmodule : xcvr_device

// >>> rtl/xcvr_host.sv
`timescale 1ns/1ps
module xcvr_host
    import xcvr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    xcvr_link_if.host link, // pins toward the device
    input wire logic [3:0] avs_address, // avalon word address
    input wire logic avs_read, // avalon read
    input wire logic avs_write, // avalon write
    input wire logic [31:0] avs_writedata, // avalon write data
    output logic [31:0] avs_readdata, // avalon read data
    output logic avs_waitrequest, // avalon wait
    output logic irq // level interrupt
);
    // ------------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------------
    logic [2:0] status_q, mask_q;
    logic tx_bit_q, tx_drive_q, rx_bit_q, load_q, cfg_wr_q, sync_q;
    logic [6:0] addr_q;
    logic [7:0] data_q;
    logic [1:0] dclk_sync_q, din_sync_q, lock_sync_q;
    logic dclk_prev_q, lock_prev_q, fall, ack_q;
    logic [31:0] rd_q;
    logic [2:0] events;

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata = rd_q;
    assign irq = |(status_q & mask_q);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dclk_sync_q <= 2'h0;
            din_sync_q <= 2'h0;
            lock_sync_q <= 2'h0;
            dclk_prev_q <= 1'b0;
            lock_prev_q <= 1'b0;
        end else begin
            dclk_sync_q <= {dclk_sync_q[0], link.data_clock_pin};
            din_sync_q <= {din_sync_q[0], link.data_io_dev_o};
            lock_sync_q <= {lock_sync_q[0], link.lock_indicator_pin};
            dclk_prev_q <= dclk_sync_q[1];
            lock_prev_q <= lock_sync_q[1];
        end
    end
    assign fall = dclk_prev_q && !dclk_sync_q[1];

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, then ack
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rd_q <= 32'h0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            if (avs_read && !ack_q) begin
                case (avs_address)
                    ADR_TX: rd_q <= {31'h0, tx_bit_q};
                    ADR_RX: rd_q <= {31'h0, rx_bit_q};
                    ADR_STAT: rd_q <= {29'h0, status_q};
                    ADR_MASK: rd_q <= {29'h0, mask_q};
                    default: rd_q <= UNMAPPED_READ;
                endcase
            end
        end
    end

    assign events = {lock_sync_q[1] && !lock_prev_q, fall, fall};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= 3'h0;
        end else if (avs_read && !avs_waitrequest
                     && avs_address == ADR_STAT) begin
            status_q <= (status_q & ~rd_q[2:0]) | events; // set wins
        end else begin
            status_q <= status_q | events;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q <= 3'h0;
            tx_bit_q <= 1'b0;
            tx_drive_q <= 1'b0;
            addr_q <= 7'h00;
            data_q <= 8'h00;
            cfg_wr_q <= 1'b0;
            load_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            cfg_wr_q <= 1'b0;
            if (cfg_wr_q && addr_q == FRONT_END_MODE_CONTROL_OFS) begin
                sync_q <= data_q[SYNC_EN_BIT];
            end
            if (avs_write && !avs_waitrequest) begin
                case (avs_address)
                    ADR_CFG: begin
                        addr_q <= avs_writedata[14:8];
                        data_q <= avs_writedata[7:0];
                        cfg_wr_q <= 1'b1;
                        load_q <= avs_writedata[16];
                    end
                    ADR_TX: begin
                        tx_bit_q <= avs_writedata[0];
                        tx_drive_q <= avs_writedata[1]; // see RULE14
                    end
                    ADR_MASK: mask_q <= avs_writedata[2:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // pin data: on data clock fall, each cycle when async
    // ------------------------------------------------------------------
    logic tx_pin_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_pin_q <= 1'b0;
            rx_bit_q <= 1'b0;
        end else if (fall || !sync_q) begin
            tx_pin_q <= tx_bit_q; // see RULE9
            rx_bit_q <= din_sync_q[1]; // see RULE10
        end
    end

    assign link.data_io_host_o = tx_pin_q;
    assign link.data_io_host_oe_n = !tx_drive_q; // see RULE14
    assign link.load_strobe = load_q; // see RULE17
    assign link.cfg_addr = addr_q;
    assign link.cfg_data = data_q;
    assign link.cfg_write = cfg_wr_q;
endmodule : xcvr_host

// >>> tb/transceiver_mode_data_interface_tb_top.sv
`timescale 1ns/1ps
module transceiver_mode_data_interface_tb_top;
    import xcvr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0;
    logic pll_locked = 1'b0, demod_data = 1'b0;
    logic mod_data, mod_sample, pump_high, avs_waitrequest, irq;
    logic [1:0] op_state;
    logic [7:0] shadow_rd;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    int n_errors = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    xcvr_link_if link ();
    xcvr_device i_xcvr_device (.clk(clk), .rstn(rstn), .link(link),
        .pll_locked(pll_locked), .demod_data(demod_data),
        .mod_data(mod_data), .mod_sample(mod_sample),
        .pump_high(pump_high), .op_state(op_state), .shadow_rd(shadow_rd));
    xcvr_host i_xcvr_host (.clk(clk), .rstn(rstn), .link(link),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));
    xcvr_link_properties i_xcvr_link_properties (.clk(clk), .rstn(rstn),
        .data_clock_pin(link.data_clock_pin),
        .data_io_dev_oe_n(link.data_io_dev_oe_n),
        .data_io_host_o(link.data_io_host_o),
        .data_io_host_oe_n(link.data_io_host_oe_n),
        .lock_indicator_pin(link.lock_indicator_pin),
        .cfg_write(link.cfg_write), .pll_locked(pll_locked),
        .mod_sample(mod_sample), .op_state(op_state));
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task give_verdict;
        $display("mismatches %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task fail_to(input string name);
        n_errors++;
        $display("CHECK FAILED %s expected answer seen timeout", name);
        give_verdict();
    endtask : fail_to
    task clks(input int n);
        repeat (n) @(posedge clk);
    endtask : clks
    task av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) fail_to("waitrequest");
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    function logic [31:0] cw(input logic ld, input logic [6:0] a,
                             input logic [7:0] d);
        return {15'h0000, ld, 1'b0, a, d};
    endfunction : cw
    task cfg(input logic [6:0] a, input logic [7:0] d);
        av(1'b1, 4'h0, cw(1'b1, a, d));
        av(1'b1, 4'h0, cw(1'b0, a, d));
        clks(8);
    endtask : cfg
    task rise_wait(output int n);
        logic p;
        p = link.data_clock_pin;
        for (n = 1; n < 9000; n++) begin
            @(negedge clk);
            if (link.data_clock_pin === 1'b1 && p === 1'b0) return;
            p = link.data_clock_pin;
        end
        fail_to("data clock rise");
    endtask : rise_wait
    task count_high(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (link.data_clock_pin === 1'b1) n++;
        end
    endtask : count_high
    task wait_sample;
        repeat (400) begin
            @(negedge clk);
            if (mod_sample === 1'b1) return;
        end
        fail_to("modulator sample");
    endtask : wait_sample
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task t_modes;
        logic [1:0] prev = 2'd0;
        logic [7:0] d;
        int n;
        for (int k = 0; k < 4; k++) begin
            d = {4'h0, 1'b1, k[1:0], 1'b0};
            av(1'b1, 4'h0, cw(1'b1, 7'h00, d));
            clks(8);
            check("held state", op_state, prev);
            check("shadow", shadow_rd, d);
            av(1'b1, 4'h0, cw(1'b0, 7'h00, d));
            clks(8);
            check("state", op_state, k[1:0]);
            count_high(300, n);
            check("clock runs", n > 0, k[1]);
            prev = k[1:0];
        end
        $display("test modes done");
    endtask : t_modes
    task t_rates;
        logic [5:0] dv [6] = '{6'd1, 6'd3, 6'd63, 6'd5, 6'd1, 6'd0};
        logic [2:0] sh [6] = '{3'd6, 3'd5, 3'd6, 3'd3, 3'd0, 3'd6};
        int n, exp;
        cfg(7'h00, 8'h0e);
        for (int k = 0; k < 6; k++) begin
            cfg(7'h06, {7'h00, sh[k][2]});
            cfg(7'h07, {sh[k][1:0], dv[k]});
            exp = 2 * (dv[k] == 6'd0 ? 1 : int'(dv[k])) * (1 << (6 - sh[k]));
            rise_wait(n);
            rise_wait(n);
            check("bit clock period", n, exp);
        end
        $display("test rates done");
    endtask : t_rates
    task t_sync_tx;
        logic b;
        cfg(7'h06, 8'h00);
        cfg(7'h07, 8'hc1);
        check("host released", link.data_io_host_oe_n, 1'b1);
        for (int k = 0; k < 3; k++) begin
            b = !k[0];
            av(1'b1, 4'h1, {30'h0, 1'b1, b});
            wait_sample();
            wait_sample();
            check("sync tx bit", mod_data, b);
        end
        av(1'b1, 4'h1, 32'h0);
        $display("test sync tx done");
    endtask : t_sync_tx
    task t_async_tx;
        int n;
        cfg(7'h00, 8'h06);
        count_high(100, n);
        check("clock off", n, 0);
        for (int k = 0; k < 2; k++) begin
            av(1'b1, 4'h1, {30'h0, 1'b1, !k[0]});
            clks(10);
            check("async tx bit", mod_data, !k[0]);
        end
        av(1'b1, 4'h1, 32'h0);
        $display("test async tx done");
    endtask : t_async_tx
    task t_rx;
        int n;
        for (int s = 0; s < 2; s++) begin
            cfg(7'h00, s ? 8'h0c : 8'h04);
            check("dev drives", link.data_io_dev_oe_n, 1'b0);
            for (int k = 0; k < 2; k++) begin
                demod_data <= !k[0];
                if (s) repeat (3) rise_wait(n);
                else clks(10);
                av(1'b0, 4'h2, 32'h0);
                check("rx bit", rd[0], !k[0]);
            end
        end
        $display("test rx done");
    endtask : t_rx
    task t_lock;
        cfg(7'h01, 8'h00);
        pll_locked <= 1'b1;
        clks(10);
        check("lock off", link.lock_indicator_pin, 1'b0);
        pll_locked <= 1'b0;
        cfg(7'h01, 8'h04);
        av(1'b0, 4'h3, 32'h0);
        av(1'b1, 4'h4, 32'h0);
        pll_locked <= 1'b1;
        clks(10);
        check("lock on", link.lock_indicator_pin, 1'b1);
        check("irq masked", irq, 1'b0);
        av(1'b1, 4'h4, 32'h4);
        clks(2);
        check("irq raised", irq, 1'b1);
        av(1'b0, 4'h3, 32'h0);
        check("lock event", rd[ST_LOCK_RISE], 1'b1);
        clks(2);
        check("irq cleared", irq, 1'b0);
        av(1'b0, 4'hf, 32'h0);
        check("unmapped", rd, UNMAPPED_READ);
        av(1'b1, 4'hf, 32'hffff_ffff);
        av(1'b0, 4'h4, 32'h0);
        check("mask", rd, 32'h4);
        pll_locked <= 1'b0;
        clks(10);
        check("lock lost", link.lock_indicator_pin, 1'b0);
        $display("test lock done");
    endtask : t_lock
    initial begin
        clks(6);
        rstn <= 1'b1;
        clks(1);
        check("reset state", op_state, OP_POWER_DOWN);
        check("reset clock", link.data_clock_pin, 1'b0);
        check("reset pump", pump_high, 1'b0);
        t_modes();
        cfg(7'h02, 8'h80);
        check("pump high", pump_high, 1'b1);
        cfg(7'h02, 8'h00);
        check("pump low", pump_high, 1'b0);
        t_rates();
        t_sync_tx();
        t_async_tx();
        t_rx();
        t_lock();
        give_verdict();
    end
endmodule : transceiver_mode_data_interface_tb_top

// >>> tb/xcvr_link_properties.sv
`timescale 1ns/1ps
module xcvr_link_properties
    import xcvr_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // reset, active low
    input wire logic data_clock_pin, // data clock to host
    input wire logic data_io_dev_oe_n, // device drive, active low
    input wire logic data_io_host_o, // host data bit
    input wire logic data_io_host_oe_n, // host drive, active low
    input wire logic lock_indicator_pin, // lock pin
    input wire logic cfg_write, // config write pulse
    input wire logic pll_locked, // loop in lock
    input wire logic mod_sample, // modulator sample pulse
    input wire logic [1:0] op_state // active operating state
);
    // ----------------------------------------------------------
    // data clock high-phase length
    // ----------------------------------------------------------
    logic [12:0] hi_cnt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hi_cnt_q <= 13'h0;
        end else begin
            hi_cnt_q <= data_clock_pin ? hi_cnt_q + 13'h1 : 13'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_cfg_one_pulse: assert property (cfg_write |=> !cfg_write)
        else $error("config write pulse too long");
    a_lock_needs_pll: assert property (!pll_locked [*4] |-> !lock_indicator_pin)
        else $error("lock pin high without lock");
    a_tx_sample_mode: assert property (
        mod_sample |-> $past(op_state) == OP_TRANSMIT)
        else $error("modulator sample outside transmit");
    a_host_chg_low: assert property ($changed(data_io_host_o) && !data_io_host_oe_n |-> !data_clock_pin)
        else $error("host data changed while clock high");
    a_no_contention: assert property (!data_io_host_oe_n |-> data_io_dev_oe_n)
        else $error("both ends drive the data pin");
    a_dev_drive_rx: assert property (!data_io_dev_oe_n |-> op_state == OP_RECEIVE || $past(op_state) == OP_RECEIVE)
        else $error("device drives data pin outside receive");
    a_clk_idle_low: assert property (data_clock_pin |-> op_state[1] || $past(op_state[1]) || $past(op_state[1], 2))
        else $error("data clock high in idle state");
    a_clk_half_max: assert property (hi_cnt_q <= 13'd4032)
        else $error("data clock high phase too long");
    cover property ($rose(data_clock_pin) && op_state == OP_TRANSMIT);
    cover property ($rose(lock_indicator_pin));
    cover property (!data_io_dev_oe_n && data_clock_pin);
    cover property (mod_sample);
endmodule : xcvr_link_properties
